// File: design/rpef_defines.svh
`ifndef RPEF_DEFINES_SVH
`define RPEF_DEFINES_SVH

// ****************************************
// register map
// ****************************************
`define RPEF_ARB_BASE    12'h000
`define RPEF_FLT_BASE    12'h100
`define RPEF_FLT_END     12'h240
`define RPEF_IRQ_STAT    12'h300
`define RPEF_IRQ_MASK    12'h304
`define RPEF_FREG_CFG    3'h0
`define RPEF_FREG_MHI    3'h1
`define RPEF_FREG_MLO    3'h2
`define RPEF_FREG_KHI    3'h3
`define RPEF_FREG_KLO    3'h4
`define RPEF_RST_ZERO    32'h0000_0000

// ****************************************
// field positions
// ****************************************
`define RPEF_ARB_USED    32'h00FF_00FF
`define RPEF_CFG_USED    32'h003F_FFFF
`define RPEF_SEL_B_SUB   23
`define RPEF_SEL_B_CLS   20
`define RPEF_SEL_B_KIND  16
`define RPEF_SEL_A_SUB   7
`define RPEF_SEL_A_CLS   4
`define RPEF_SEL_A_KIND  0
`define RPEF_CFG_EN      21
`define RPEF_CFG_DC      20
`define RPEF_CFG_POS_MSB 19
`define RPEF_CFG_POS_LSB 16
`define RPEF_MC_MSB      12
`define RPEF_MC_LSB      9
`define RPEF_OPC_MSB     8
`define RPEF_OPC_LSB     5
`define RPEF_STATE_MSB   51
`define RPEF_STATE_LSB   48

// ****************************************
// codes and counts
// ****************************************
`define RPEF_MC_DATA_RESP 4'hE
`define RPEF_OPC_STATE_MAX 4'h2
`define RPEF_KIND_LAST    4'hC
`define RPEF_KIND_GAP     2'h3
`define RPEF_LARGE_MIN    4'h9
`define RPEF_LARGE_MAX    4'hB
`define RPEF_SMALL_MIN    4'h1
`define RPEF_SMALL_MAX    4'h3

`endif

// File: design/rpef_pkg.sv
package rpef_pkg;
   typedef enum logic [2:0] {
      home_class                 = 3'b000,
      snoop_class                = 3'b001,
      nondata_response_class     = 3'b010,
      noncoherent_standard_class = 3'b011,
      data_response_class        = 3'b100,
      noncoherent_bypass_class   = 3'b101,
      adaptive_large             = 3'b110,
      adaptive_small             = 3'b111
   } rpef_class_t;
endpackage

// File: design/rpef_filter.sv
`timescale 1ns/100ps
`include "rpef_defines.svh"
module rpef_filter (
   input  wire logic        pclk,       // core clock
   input  wire logic        presetn,    // async reset, active low
   input  wire logic        flit_valid, // flit crossing this port
   input  wire logic        flit_sop,   // first flit of a packet
   input  wire logic [71:0] flit,       // flit contents
   input  wire logic [31:0] cfg,        // configuration word
   input  wire logic [71:0] match_val,  // full match value
   input  wire logic [71:0] mask_val,   // full mask value
   output logic             match_evt   // one-cycle match pulse
);
   logic [3:0]  pos;
   logic [3:0]  next_pos;
   logic [3:0]  cur_pos;
   logic        next_evt;
   logic        state_live;
   logic [71:0] eff_mask;

   always_comb begin
      // position saturates so very long packets never wrap back to 0
      cur_pos = flit_sop ? 4'h0 : ((pos == 4'hF) ? pos : pos + 4'h1);
      next_pos = flit_valid ? cur_pos : pos;
      // state only valid for data response
      state_live = (flit[`RPEF_MC_MSB:`RPEF_MC_LSB] == `RPEF_MC_DATA_RESP) &&
                   (flit[`RPEF_OPC_MSB:`RPEF_OPC_LSB] <= `RPEF_OPC_STATE_MAX);
      eff_mask = mask_val;
      if (!state_live) begin
         eff_mask[`RPEF_STATE_MSB:`RPEF_STATE_LSB] = 4'h0;
      end
      next_evt = cfg[`RPEF_CFG_EN] && flit_valid &&
                 (((flit ^ match_val) & eff_mask) == 72'h0) &&
                 (cfg[`RPEF_CFG_DC] || cur_pos == cfg[`RPEF_CFG_POS_MSB:`RPEF_CFG_POS_LSB]);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pos       <= 4'hF;
         match_evt <= 1'b0;
      end else begin
         pos       <= next_pos;
         match_evt <= next_evt;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_off;
      !cfg[`RPEF_CFG_EN] |=> !match_evt;
   endproperty
   a_off: assert property (p_off) else $error("filter fired while disabled");

   property p_hit;
      cfg[`RPEF_CFG_EN] && cfg[`RPEF_CFG_DC] && flit_valid && mask_val[51:48] == 4'h0 &&
      ((flit ^ match_val) & mask_val) == 72'h0 |=> match_evt;
   endproperty
   a_hit: assert property (p_hit) else $error("matching flit gave no event");

   property p_miss;
      flit_valid && ((flit[47:0] ^ match_val[47:0]) & mask_val[47:0]) != 48'h0 |=> !match_evt;
   endproperty
   a_miss: assert property (p_miss) else $error("masked mismatch still fired");

   property p_first;
      cfg[`RPEF_CFG_EN] && !cfg[`RPEF_CFG_DC] && cfg[19:16] == 4'h0 && flit_valid && !flit_sop
      |=> !match_evt;
   endproperty
   a_first: assert property (p_first) else $error("non-header flit fired at position 0");

   property p_pulse;
      !flit_valid |=> !match_evt;
   endproperty
   a_pulse: assert property (p_pulse) else $error("event without a flit");

   c_match: cover property (match_evt ##1 match_evt);
endmodule

// File: design/rpef_top.sv
// Operation
// - each arbiter select register holds two selectors whose VN bit sits at 23 and 7.
// - each selector has a three-bit class field naming one of eight message classes.
// - adaptive class 110 counts 9 to 11 flit packets and 111 counts 1 to 3 flit packets.
// - a four-bit kind field picks queue, local or global bid, fail or home-order kill.
// - kind 1011 is target available, 1100 is depth overflow, other gaps are reserved.
// - unused arbiter select bits read zero and ignore writes, and all fields reset to zero.
// - each of the five ports has two match/mask filters on crossing flits.
// - a filter fires only while its enable bit 21 is set, which resets to zero.
// - configuration bit 20 makes every flit of a packet a candidate.
// - a four-bit position field picks which flit of a packet may match, 0 being the header.
// - the configuration word holds match bits 71:64 in 15:8 and mask bits 71:64 in 7:0.
// - the response data state bits only take part for data responses with opcode 0 to 2.
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/100ps
`include "rpef_defines.svh"
module rpef_top (
   input  wire logic         pclk,             // core clock, 50 MHz
   input  wire logic         presetn,          // async reset, active low
   input  wire logic         psel,             // apb select
   input  wire logic         penable,          // apb enable
   input  wire logic         pwrite,           // apb direction
   input  wire logic [11:0]  paddr,            // apb byte address
   input  wire logic [31:0]  pwdata,           // apb write data
   output logic              pready,           // apb ready
   output logic [31:0]       prdata,           // apb read data
   output logic              pslverr,          // apb error, unmapped address
   input  wire logic [4:0]   arb_occ_valid,    // arbitration occurrence per arbiter
   input  wire logic [19:0]  arb_occ_kind,     // stage and outcome, 4 bits each
   input  wire logic [14:0]  arb_occ_class,    // message class, 3 bits each
   input  wire logic [4:0]   arb_occ_vn,       // virtual net of the occurrence
   input  wire logic [4:0]   arb_occ_adaptive, // occurrence on the adaptive network
   input  wire logic [19:0]  arb_occ_flits,    // packet length in flits, 4 bits each
   input  wire logic [4:0]   port_flit_valid,  // flit crossing each port
   input  wire logic [4:0]   port_flit_sop,    // first flit of a packet
   input  wire logic [359:0] port_flit,        // 72-bit flit per port
   output logic [4:0]        arb_event_a,      // selector a pulse per arbiter
   output logic [4:0]        arb_event_b,      // selector b pulse per arbiter
   output logic [9:0]        filter_event,     // match pulse, bit 2*port+pair
   output logic              irq               // unmasked filter status pending
);
   // ****************************************
   // storage
   // ****************************************
   logic [31:0] arb_sel [5];
   logic [31:0] flt_cfg [10];
   logic [31:0] match_hi [10];
   logic [31:0] match_lo [10];
   logic [31:0] mask_hi [10];
   logic [31:0] mask_lo [10];
   logic [9:0]  irq_stat;
   logic [9:0]  irq_mask;
   logic [31:0] next_arb_sel [5];
   logic [31:0] next_flt_cfg [10];
   logic [31:0] next_match_hi [10];
   logic [31:0] next_match_lo [10];
   logic [31:0] next_mask_hi [10];
   logic [31:0] next_mask_lo [10];
   logic [9:0]  next_irq_stat;
   logic [9:0]  next_irq_mask;
   logic        next_irq;
   logic        next_pready;
   logic [31:0] next_prdata;
   logic        next_pslverr;
   logic [4:0]  next_arb_a;
   logic [4:0]  next_arb_b;

   // ****************************************
   // address decode
   // ****************************************
   logic [11:0] flt_off;
   logic [3:0]  fidx;
   logic [2:0]  freg;
   logic [2:0]  aidx;
   logic        is_arb;
   logic        is_flt;
   logic        is_stat;
   logic        is_mask;
   logic        hit;
   logic        wr_go;

   always_comb begin
      flt_off = paddr - `RPEF_FLT_BASE;
      // filter index is 2*port+pair: port in bits 8:6, pair in bit 5
      fidx    = flt_off[8:5];
      freg    = flt_off[4:2];
      aidx    = paddr[4:2];
      is_arb  = (paddr[11:5] == 7'h00) && (aidx < 3'h5);
      is_flt  = (paddr >= `RPEF_FLT_BASE) && (paddr < `RPEF_FLT_END) && (freg < 3'h5);
      is_stat = (paddr == `RPEF_IRQ_STAT);
      is_mask = (paddr == `RPEF_IRQ_MASK);
      hit     = is_arb || is_flt || is_stat || is_mask;
      // writes land only on the edge that also sees pready high
      wr_go   = psel && penable && pready && pwrite;
   end

   // ****************************************
   // apb answer
   // ****************************************
   always_comb begin
      // one wait state gives the read mux a full cycle
      next_pready  = psel && penable && !pready;
      next_prdata  = `RPEF_RST_ZERO;
      next_pslverr = 1'b0;
      if (next_pready) begin
         next_pslverr = !hit;
         if (is_arb) begin
            next_prdata = arb_sel[aidx];
         end else if (is_flt) begin
            unique case (freg)
               `RPEF_FREG_CFG: next_prdata = flt_cfg[fidx];
               `RPEF_FREG_MHI: next_prdata = match_hi[fidx];
               `RPEF_FREG_MLO: next_prdata = match_lo[fidx];
               `RPEF_FREG_KHI: next_prdata = mask_hi[fidx];
               default:        next_prdata = mask_lo[fidx];
            endcase
         end else if (is_stat) begin
            next_prdata = {22'h0, irq_stat};
         end else if (is_mask) begin
            next_prdata = {22'h0, irq_mask};
         end
      end
   end

   // ****************************************
   // register writes
   // ****************************************
   always_comb begin
      next_arb_sel  = arb_sel;
      next_flt_cfg  = flt_cfg;
      next_match_hi = match_hi;
      next_match_lo = match_lo;
      next_mask_hi  = mask_hi;
      next_mask_lo  = mask_lo;
      next_irq_mask = irq_mask;
      if (wr_go && is_arb) begin
         next_arb_sel[aidx] = pwdata & `RPEF_ARB_USED;
      end
      if (wr_go && is_flt) begin
         unique case (freg)
            `RPEF_FREG_CFG: next_flt_cfg[fidx] = pwdata & `RPEF_CFG_USED;
            `RPEF_FREG_MHI: next_match_hi[fidx] = pwdata;
            `RPEF_FREG_MLO: next_match_lo[fidx] = pwdata;
            `RPEF_FREG_KHI: next_mask_hi[fidx] = pwdata;
            default:        next_mask_lo[fidx] = pwdata;
         endcase
      end
      if (wr_go && is_mask) begin
         next_irq_mask = pwdata[9:0];
      end
      // a match in the clearing cycle stays set
      next_irq_stat = irq_stat & ~((wr_go && is_stat) ? pwdata[9:0] : 10'h000);
      next_irq_stat = next_irq_stat | filter_event;
      next_irq      = |(next_irq_stat & next_irq_mask);
   end

   // ****************************************
   // arbiter event selection
   // ****************************************
   function automatic logic sel_hit(input logic       sub,
                                    input logic [2:0] cls,
                                    input logic [3:0] kind,
                                    input logic       vn,
                                    input logic [2:0] ocls,
                                    input logic       adap,
                                    input logic [3:0] flits,
                                    input logic [3:0] okind);
      logic kind_ok;
      logic cls_ok;
      kind_ok = (kind <= `RPEF_KIND_LAST) && !(!kind[3] && kind[1:0] == `RPEF_KIND_GAP);
      // adaptive classes go by packet length
      if (cls == rpef_pkg::adaptive_large) begin
         cls_ok = adap && flits >= `RPEF_LARGE_MIN && flits <= `RPEF_LARGE_MAX;
      end else if (cls == rpef_pkg::adaptive_small) begin
         cls_ok = adap && flits >= `RPEF_SMALL_MIN && flits <= `RPEF_SMALL_MAX;
      end else begin
         cls_ok = !adap && ocls == cls && vn == sub;
      end
      sel_hit = kind_ok && cls_ok && okind == kind;
   endfunction

   always_comb begin
      for (int i = 0; i < 5; i++) begin
         next_arb_a[i] = arb_occ_valid[i] &&
            sel_hit(arb_sel[i][`RPEF_SEL_A_SUB], arb_sel[i][`RPEF_SEL_A_CLS +: 3],
                    arb_sel[i][`RPEF_SEL_A_KIND +: 4], arb_occ_vn[i], arb_occ_class[3*i +: 3],
                    arb_occ_adaptive[i], arb_occ_flits[4*i +: 4], arb_occ_kind[4*i +: 4]);
         next_arb_b[i] = arb_occ_valid[i] &&
            sel_hit(arb_sel[i][`RPEF_SEL_B_SUB], arb_sel[i][`RPEF_SEL_B_CLS +: 3],
                    arb_sel[i][`RPEF_SEL_B_KIND +: 4], arb_occ_vn[i], arb_occ_class[3*i +: 3],
                    arb_occ_adaptive[i], arb_occ_flits[4*i +: 4], arb_occ_kind[4*i +: 4]);
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 5; i++) begin
            arb_sel[i] <= `RPEF_RST_ZERO;
         end
         for (int i = 0; i < 10; i++) begin
            flt_cfg[i]  <= `RPEF_RST_ZERO;
            match_hi[i] <= `RPEF_RST_ZERO;
            match_lo[i] <= `RPEF_RST_ZERO;
            mask_hi[i]  <= `RPEF_RST_ZERO;
            mask_lo[i]  <= `RPEF_RST_ZERO;
         end
         irq_stat    <= 10'h000;
         irq_mask    <= 10'h000;
         irq         <= 1'b0;
         pready      <= 1'b0;
         prdata      <= `RPEF_RST_ZERO;
         pslverr     <= 1'b0;
         arb_event_a <= 5'h00;
         arb_event_b <= 5'h00;
      end else begin
         arb_sel     <= next_arb_sel;
         flt_cfg     <= next_flt_cfg;
         match_hi    <= next_match_hi;
         match_lo    <= next_match_lo;
         mask_hi     <= next_mask_hi;
         mask_lo     <= next_mask_lo;
         irq_stat    <= next_irq_stat;
         irq_mask    <= next_irq_mask;
         irq         <= next_irq;
         pready      <= next_pready;
         prdata      <= next_prdata;
         pslverr     <= next_pslverr;
         arb_event_a <= next_arb_a;
         arb_event_b <= next_arb_b;
      end
   end

   // ****************************************
   // filters
   // ****************************************
   // two filters per port
   for (genvar g = 0; g < 10; g++) begin : g_flt
      rpef_filter u_flt (
         .pclk       (pclk),
         .presetn    (presetn),
         .flit_valid (port_flit_valid[g/2]),
         .flit_sop   (port_flit_sop[g/2]),
         .flit       (port_flit[72*(g/2) +: 72]),
         .cfg        (flt_cfg[g]),
         // upper bytes from the configuration word
         .match_val  ({flt_cfg[g][15:8], match_hi[g], match_lo[g]}),
         .mask_val   ({flt_cfg[g][7:0], mask_hi[g], mask_lo[g]}),
         .match_evt  (filter_event[g])
      );
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_rsv_zero;
      pready && !pslverr && paddr[11:5] == 7'h00 |-> prdata[31:24] == 8'h00 && prdata[15:8] == 8'h00;
   endproperty
   a_rsv_zero: assert property (p_rsv_zero) else $error("unused select bits read nonzero");

   property p_sel_a;
      arb_occ_valid[3] && !arb_occ_adaptive[3] && arb_sel[3][3:0] == 4'h5 &&
      arb_occ_kind[15:12] == 4'h5 && arb_occ_class[11:9] == arb_sel[3][6:4] &&
      arb_occ_class[11:9] != 3'b110 && arb_occ_class[11:9] != 3'b111 &&
      arb_occ_vn[3] == arb_sel[3][7] |=> arb_event_a[3];
   endproperty
   a_sel_a: assert property (p_sel_a) else $error("selector a missed its occurrence");

   property p_vn;
      arb_occ_valid[3] && !arb_occ_adaptive[3] && arb_occ_vn[3] != arb_sel[3][23] |=> !arb_event_b[3];
   endproperty
   a_vn: assert property (p_vn) else $error("selector b counted wrong virtual net");

   property p_large;
      arb_occ_valid[3] && arb_occ_adaptive[3] && arb_occ_flits[15:12] == 4'hA &&
      arb_sel[3][22:20] == 3'b110 && arb_sel[3][19:16] == 4'hB && arb_occ_kind[15:12] == 4'hB
      |=> arb_event_b[3];
   endproperty
   a_large: assert property (p_large) else $error("large adaptive packet not counted");

   property p_rsv_kind;
      arb_sel[3][3:0] == 4'h7 || arb_sel[3][3:0] == 4'hE |=> !arb_event_a[3];
   endproperty
   a_rsv_kind: assert property (p_rsv_kind) else $error("reserved kind produced an event");

   c_arb_a: cover property (arb_event_a[3]);
   c_irq: cover property (irq && filter_event != 10'h000);
endmodule

// File: verification/rpef_port_model.sv
`timescale 1ns/100ps
module rpef_port_model (
   input  wire logic         pclk,            // core clock
   input  wire logic         presetn,         // async reset, active low
   input  wire logic         send,            // put one flit on a port next cycle
   input  wire logic         send_sop,        // that flit opens a packet
   input  wire logic [2:0]   send_port,       // port that carries it
   input  wire logic [71:0]  send_flit,       // flit contents
   output logic      [4:0]   port_flit_valid, // flit crossing each port
   output logic      [4:0]   port_flit_sop,   // first flit of a packet
   output logic      [359:0] port_flit        // 72-bit flit per port
);
   // ****************************************
   // flit source for the router ports
   // ****************************************
   // flits cross ports
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_flit_valid <= '0;
         port_flit_sop   <= '0;
         port_flit       <= '0;
      end else begin
         // idle lanes flip every cycle so stale data never looks valid
         port_flit       <= ~port_flit;
         port_flit_valid <= send ? (5'h01 << send_port) : 5'h00;
         port_flit_sop   <= (send && send_sop) ? (5'h01 << send_port) : 5'h00;
         if (send) begin
            port_flit[72*send_port +: 72] <= send_flit;
         end
      end
   end
endmodule

// File: verification/rpef_top_test.sv
`timescale 1ns/100ps
module rpef_top_test;
   logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0]  paddr = 12'h000;
   logic [31:0]  pwdata = 32'h0000_0000, prdata;
   logic         pready, pslverr, irq;
   logic [4:0]   arb_occ_valid = 5'h00, arb_occ_vn = 5'h00, arb_occ_adaptive = 5'h00;
   logic [19:0]  arb_occ_kind = 20'h00000, arb_occ_flits = 20'h00000;
   logic [14:0]  arb_occ_class = 15'h0000;
   logic [4:0]   port_flit_valid, port_flit_sop, arb_event_a, arb_event_b;
   logic [359:0] port_flit;
   logic [9:0]   filter_event;
   logic         send = 1'b0, send_sop = 1'b0;
   logic [2:0]   send_port = 3'h0;
   logic [71:0]  send_flit = 72'h0;
   logic [15:0]  rnd = 16'hD798;
   int           num_errors = 0, comparisons = 0;
   logic [32:0]  exp_rd[$];
   logic [19:0]  exp_ev[$];

   always #10 pclk = ~pclk;

   rpef_top rpef_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
      .pslverr, .arb_occ_valid, .arb_occ_kind, .arb_occ_class, .arb_occ_vn, .arb_occ_adaptive,
      .arb_occ_flits, .port_flit_valid, .port_flit_sop, .port_flit, .arb_event_a, .arb_event_b,
      .filter_event, .irq);
   rpef_port_model rpef_port_model_i (.pclk, .presetn, .send, .send_sop, .send_port, .send_flit,
      .port_flit_valid, .port_flit_sop, .port_flit);

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task report_and_stop();
      if (num_errors == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task check(input string what, input logic [32:0] seen, input logic [32:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // entered just after an edge, leaves just after an edge with the bus idle
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         num_errors++;
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task rd(input logic [11:0] a, input logic [32:0] e);
      exp_rd.push_back(e);
      apb(1'b0, a, 32'h0000_0000);
   endtask

   // one occurrence on arbiter 3
   task occ(input logic [3:0] k, input logic [2:0] c, input logic v, input logic ad, input logic [3:0] fl,
            input logic [19:0] e);
      arb_occ_valid <= 5'h08;
      arb_occ_kind <= 20'(k) << 12;
      arb_occ_class <= 15'(c) << 9;
      arb_occ_vn <= 5'(v) << 3;
      arb_occ_adaptive <= 5'(ad) << 3;
      arb_occ_flits <= 20'(fl) << 12;
      if (e !== 20'h00000) begin
         exp_ev.push_back(e);
      end
      @(posedge pclk);
      arb_occ_valid <= 5'h00;
      repeat (2) @(posedge pclk);
   endtask

   // packet of n flits on port p; hits marks the flits expected to fire filter bit fb
   task pkt(input logic [2:0] p, input int n, input logic [7:0] hi, input logic [3:0] cls,
            input logic [3:0] opc, input logic [3:0] st, input logic [15:0] hits, input int fb);
      logic [71:0] f;
      for (int i = 0; i < n; i++) begin
         rnd = lfsr(rnd);
         f = {hi, {4{rnd}}};
         f[51:48] = st;
         f[12:9] = cls;
         f[8:5] = opc;
         send <= 1'b1;
         send_sop <= (i == 0);
         send_port <= p;
         send_flit <= f;
         if (hits[i]) begin
            exp_ev.push_back(20'h00001 << fb);
         end
         @(posedge pclk);
      end
      send <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask

   // ****************************************
   // result watcher
   // ****************************************
   always @(posedge pclk) begin
      if (pready === 1'b1 && psel === 1'b1 && pwrite === 1'b0) begin
         check("read", {pslverr, prdata}, exp_rd.size() > 0 ? exp_rd.pop_front() : 33'hx);
      end
      if ({arb_event_a, arb_event_b, filter_event} !== 20'h00000) begin
         check("event", 33'({arb_event_a, arb_event_b, filter_event}),
               33'(exp_ev.size() > 0 ? exp_ev.pop_front() : 20'h00000));
      end
   end

   initial begin
      #400000;
      num_errors++;
      report_and_stop();
   end

   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(12'h00C, 33'h0_0000_0000);
      rd(12'h1A0, 33'h0_0000_0000);
      wr(12'h00C, 32'hFFFF_FFFF);
      rd(12'h00C, 33'h0_00FF_00FF);
      rd(12'h0F0, 33'h1_0000_0000);
      for (int k = 0; k < 16; k++) begin
         wr(12'h00C, {28'h0070_00A, 4'(k)});
         occ(4'(k), 3'h2, 1'b1, 1'b0, 4'h0, (k inside {3, 7, 13, 14, 15}) ? 20'h00000 : 20'h40000);
      end
      occ(4'h0, 3'h2, 1'b0, 1'b0, 4'h0, 20'h00000);
      for (int c = 0; c < 8; c++) begin
         wr(12'h00C, {9'h000, 3'(c), 4'hB, 16'h0003});
         occ(4'hB, 3'(c), 1'b0, c >= 6, (c == 6) ? 4'hA : 4'h2, 20'h02000);
      end
      occ(4'hB, 3'h7, 1'b0, 1'b1, 4'h4, 20'h00000);
      occ(4'hB, 3'h7, 1'b0, 1'b1, 4'h1, 20'h02000);
      wr(12'h00C, 32'h00AB_0003);
      occ(4'hB, 3'h2, 1'b1, 1'b0, 4'h0, 20'h02000);
      occ(4'hB, 3'h2, 1'b0, 1'b0, 4'h0, 20'h00000);
      // filter on port 2 pair 1: class field and upper byte compared, rest random
      wr(12'h1A8, 32'h0000_1C00);
      wr(12'h1B0, 32'h0000_1E00);
      wr(12'h1A0, 32'h0021_A5FF);
      rd(12'h1A0, 33'h0_0021_A5FF);
      wr(12'h304, 32'h0000_0020);
      pkt(3'h2, 4, 8'hA5, 4'hE, 4'h5, 4'h0, 16'h0002, 5);
      check("irq", 33'(irq), 33'h1);
      wr(12'h300, 32'h0000_0020);
      check("irq", 33'(irq), 33'h0);
      pkt(3'h2, 3, 8'hA4, 4'hE, 4'h5, 4'h0, 16'h0000, 5);
      pkt(3'h2, 3, 8'hA5, 4'hC, 4'h5, 4'h0, 16'h0000, 5);
      wr(12'h1A0, 32'h0020_A5FF);
      pkt(3'h2, 3, 8'hA5, 4'hE, 4'h5, 4'h0, 16'h0001, 5);
      wr(12'h1A0, 32'h0031_A5FF);
      pkt(3'h2, 3, 8'hA5, 4'hE, 4'h5, 4'h0, 16'h0007, 5);
      wr(12'h1A4, 32'h0008_0000);
      wr(12'h1AC, 32'h000F_0000);
      pkt(3'h2, 2, 8'hA5, 4'hE, 4'h1, 4'h0, 16'h0000, 5);
      pkt(3'h2, 2, 8'hA5, 4'hE, 4'h1, 4'h8, 16'h0003, 5);
      pkt(3'h2, 2, 8'hA5, 4'hE, 4'h5, 4'h0, 16'h0003, 5);
      wr(12'h304, 32'h0000_0000);
      check("irq", 33'(irq), 33'h0);
      rd(12'h300, 33'h0_0000_0020);
      wr(12'h300, 32'h0000_0020);
      rd(12'h300, 33'h0_0000_0000);
      wr(12'h1A0, 32'h0011_A5FF);
      pkt(3'h2, 3, 8'hA5, 4'hE, 4'h5, 4'h0, 16'h0000, 5);
      wr(12'h100, 32'h0030_0000);
      pkt(3'h0, 2, 8'h00, 4'h3, 4'h0, 4'h0, 16'h0003, 0);
      pkt(3'h2, 2, 8'h00, 4'h3, 4'h0, 4'h0, 16'h0000, 0);
      repeat (5) @(posedge pclk);
      check("read_queue", 33'(exp_rd.size()), 33'h0);
      check("event_queue", 33'(exp_ev.size()), 33'h0);
      report_and_stop();
   end
endmodule
